// ---- src/astu_pkg.sv ----
// Purpose: shared constants, types and helpers of the async serial transmit unit
// Assumes: byte-wide register port, one system clock
// Notes: mode and baud registers are viewed through packed structs
package astu_pkg;

	localparam logic [15:0] ADDR_PORT_LATCH = 16'hFF01;
	localparam logic [15:0] ADDR_PORT_DIR = 16'hFF21;
	localparam logic [15:0] ADDR_MODE = 16'hFF70;
	localparam logic [15:0] ADDR_BAUD = 16'hFF71;
	localparam logic [15:0] ADDR_RX_STATUS = 16'hFF73;
	localparam logic [15:0] ADDR_TX_SHIFT = 16'hFF75;
	localparam logic [15:0] ADDR_RX_BUFFER = 16'hFF76;

	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] BAUD_RST = 8'h1F;
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	localparam logic [7:0] MODE_FIXED_ONES = 8'h01;
	localparam logic [7:0] BAUD_WRITE_MASK = 8'hDF;
	localparam logic [7:0] DIR_FIXED_ONES = 8'hF1;

	localparam int DIR_OUT_BIT = 3;
	localparam int DIR_IN_BIT = 2;
	localparam int LATCH_OUT_BIT = 3;
	localparam int ST_PE_BIT = 2;
	localparam int ST_FE_BIT = 1;
	localparam int ST_OVE_BIT = 0;

	localparam logic [4:0] K_MIN = 5'h08;
	localparam logic [4:0] PRE_END_DIV2 = 5'h01;
	localparam logic [4:0] PRE_END_DIV8 = 5'h07;
	localparam logic [4:0] PRE_END_DIV32 = 5'h1F;
	localparam logic [2:0] LAST_BIT_8 = 3'h7;
	localparam logic [2:0] LAST_BIT_7 = 3'h6;

	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ZERO = 2'b01,
		PAR_ODD = 2'b10,
		PAR_EVEN = 2'b11
	} astu_parity_t;

	typedef struct packed {
		logic power;
		logic tx_en;
		logic rx_en;
		astu_parity_t parity;
		logic char8;
		logic stop2;
		logic fixed_one;
	} astu_mode_t;

	typedef struct packed {
		logic [1:0] base_sel;
		logic rsvd;
		logic [4:0] div_k;
	} astu_baud_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP1 = 3'b100,
		TX_STOP2 = 3'b101
	} astu_tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP = 3'b100
	} astu_rx_state_t;

	// xor of the character bits, bit 7 only counts for 8-bit characters
	function automatic logic astu_char_parity(input logic [7:0] data, input logic char8);
		astu_char_parity = ^{data[7] & char8, data[6:0]};
	endfunction

	function automatic logic [4:0] astu_clamp_k(input logic [4:0] k);
		astu_clamp_k = (k < K_MIN) ? K_MIN : k;
	endfunction

endpackage

// ---- src/astu_bitclk.sv ----
// Purpose: bit timing counter, divides the base tick by 2k
// Assumes: base_tick is a one-cycle enable on clk
// Notes: mid_tick marks half a bit after clear, then every bit
`timescale 1ns/10ps
`default_nettype none
module astu_bitclk
	import astu_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic base_tick,
	input wire logic [4:0] div_k,
	output logic mid_tick,
	output logic bit_tick
);

	logic [5:0] cnt;
	logic [4:0] k_eff;
	logic [5:0] half_end;
	logic [5:0] full_end;

	assign k_eff = astu_clamp_k(div_k);
	assign half_end = {1'b0, k_eff} - 6'h01;
	assign full_end = {k_eff, 1'b0} - 6'h01;
	assign mid_tick = base_tick && (cnt == half_end);
	assign bit_tick = base_tick && (cnt == full_end);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt <= 6'h00;
		else if (clear)
			cnt <= 6'h00;
		else if (base_tick)
			cnt <= bit_tick ? 6'h00 : cnt + 6'h01;
	end

	a_ticks_apart: assert property (@(posedge clk) disable iff (!rst_n)
		bit_tick |-> !mid_tick)
		else $error("mid and bit tick coincide");

endmodule // astu_bitclk
`default_nettype wire

// ---- src/astu_top.sv ----
// Purpose: async serial unit with mode control, transmit path and parity receive
// Assumes: register port on SYS_CLK, serial input asynchronous to it
// Notes: the power bit acts as an asynchronous reset of the unit logic
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R01 - power, transmit and receive enables all clear: stop mode, pins are port pins
// R02 - reset loads mode register with 01H, only fixed bit 0 set
// R03 - power clear stops base clock and asynchronously resets unit logic
// R04 - power clear also resets error status, transmit data and receive buffer
// R05 - power clear forces the internal serial input high
// R06 - transmit enable clear synchronously resets the transmit circuit
// R07 - receive enable clear synchronously resets the receive circuit
// R08 - software clears enables before power, sets power before enables
// R09 - software sets baud, then format, power, enables, then first data
// R10 - pins serve the unit only with power, enable and matching direction
// R11 - frame: start, 7 or 8 bits LSB first, optional parity, 1-2 stops
// R12 - even parity transmit: parity bit makes the ones count even
// R13 - even parity receive: odd ones count including parity is an error
// R14 - odd parity transmit: parity bit makes the ones count odd
// R15 - odd parity receive: even ones count including parity is an error
// R16 - zero parity: send 0, receiver never reports a parity error
// R17 - no parity: no parity bit either way, never a parity error
// R18 - with power and transmit enable, a data write starts a frame
// R19 - start bit first, then data from LSB, then parity and stops
// R20 - transmit done request right after the final stop bit
// R21 - after a frame the transmitter idles until new data is written
// R22 - software waits for transmit done before writing the next data
// R23 - parity field: 00 none, 01 zero, 10 odd, 11 even
// R24 - length bit: 0 seven, 1 eight bits; stop bit: 0 one, 1 two
// R25 - enabled but idle transmitter holds the line high
module astu_top
	import astu_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [15:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic TIMER_TICK_IN,
	input wire logic SERIAL_IN,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_OE_N,
	output logic TX_DONE_IRQ,
	output logic RX_DONE_IRQ
);

	logic [7:0] mode_reg;
	logic [7:0] baud_reg;
	logic [7:0] dir_reg;
	logic [7:0] latch_reg;
	logic [7:0] status_reg;
	logic [7:0] tx_data;
	logic [7:0] tx_sh;
	logic [7:0] rx_buf;
	logic [7:0] rx_sh;
	logic [7:0] rd_value;
	logic [7:0] rx_char;
	logic [7:0] status_set;
	logic [7:0] status_keep;
	logic [4:0] pre_cnt;
	logic [4:0] pre_end;
	logic [2:0] tx_cnt;
	logic [2:0] rx_cnt;
	logic [2:0] last_bit;
	astu_mode_t mode;
	astu_baud_t baud;
	astu_tx_state_t tx_state;
	astu_rx_state_t rx_state;
	logic unit_rst_n;
	logic wr_mode, wr_baud, wr_dir, wr_latch, wr_tx;
	logic rd_status, rd_rxbuf;
	logic base_tick;
	logic tx_start, tx_clear, tx_mid, tx_tick, tx_line, tx_par_bit;
	logic rx_clear, rx_mid, rx_tick, rx_raw, rx_sync1, rx_sync2, rx_filt, rx_view, rx_prev;
	logic rx_fall, rx_pbit, rx_full, rx_finish, rx_perr, rx_ferr, rx_ovr, rx_store;
	logic tx_owns_pin, next_serial_out;

	assign mode = astu_mode_t'(mode_reg);
	assign baud = astu_baud_t'(baud_reg);
	// power low holds every unit flop in reset, standing in for the stopped clock
	assign unit_rst_n = RST_N & mode.power; // R03

	// register port decode
	assign wr_mode = REG_WR && (REG_ADDR == ADDR_MODE);
	assign wr_baud = REG_WR && (REG_ADDR == ADDR_BAUD);
	assign wr_dir = REG_WR && (REG_ADDR == ADDR_PORT_DIR);
	assign wr_latch = REG_WR && (REG_ADDR == ADDR_PORT_LATCH);
	assign wr_tx = REG_WR && (REG_ADDR == ADDR_TX_SHIFT);
	assign rd_status = REG_RD && (REG_ADDR == ADDR_RX_STATUS);
	assign rd_rxbuf = REG_RD && (REG_ADDR == ADDR_RX_BUFFER);

	always_comb
	begin
		if (REG_ADDR == ADDR_MODE)
			rd_value = mode_reg;
		else if (REG_ADDR == ADDR_BAUD)
			rd_value = baud_reg;
		else if (REG_ADDR == ADDR_RX_STATUS)
			rd_value = status_reg;
		else if (REG_ADDR == ADDR_TX_SHIFT)
			rd_value = tx_data;
		else if (REG_ADDR == ADDR_RX_BUFFER)
			rd_value = rx_buf;
		else if (REG_ADDR == ADDR_PORT_DIR)
			rd_value = dir_reg;
		else if (REG_ADDR == ADDR_PORT_LATCH)
			rd_value = latch_reg;
		else
			rd_value = 8'h00;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			REG_RDATA <= 8'h00;
		else
			REG_RDATA <= REG_RD ? rd_value : 8'h00;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			mode_reg <= MODE_RST; // R02
			baud_reg <= BAUD_RST;
			dir_reg <= DIR_RST;
			latch_reg <= LATCH_RST;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= REG_WDATA | MODE_FIXED_ONES;
			if (wr_baud)
				baud_reg <= REG_WDATA & BAUD_WRITE_MASK;
			if (wr_dir)
				dir_reg <= REG_WDATA | DIR_FIXED_ONES;
			if (wr_latch)
				latch_reg <= REG_WDATA;
		end
	end

	// base clock prescaler, select 00 takes the external timer tick
	assign pre_end = (baud.base_sel == 2'b01) ? PRE_END_DIV2 :
		(baud.base_sel == 2'b10) ? PRE_END_DIV8 : PRE_END_DIV32;
	assign base_tick = (baud.base_sel == 2'b00) ? TIMER_TICK_IN : (pre_cnt == pre_end);

	always_ff @(posedge SYS_CLK or negedge unit_rst_n)
	begin
		if (!unit_rst_n)
			pre_cnt <= 5'h00; // R03
		else if ((baud.base_sel == 2'b00) || (pre_cnt == pre_end))
			pre_cnt <= 5'h00;
		else
			pre_cnt <= pre_cnt + 5'h01;
	end

	// transmit path
	assign last_bit = mode.char8 ? LAST_BIT_8 : LAST_BIT_7; // R24
	assign tx_start = wr_tx && mode.power && mode.tx_en && (tx_state == TX_IDLE); // R18
	assign tx_clear = tx_start || !mode.tx_en || (tx_state == TX_IDLE);
	assign tx_par_bit = (mode.parity == PAR_ZERO) ? 1'b0 : // R16
		(mode.parity == PAR_ODD) ? ~astu_char_parity(tx_data, mode.char8) : // R14
		astu_char_parity(tx_data, mode.char8); // R12

	astu_bitclk u_tx_clk (
		.clk(SYS_CLK),
		.rst_n(unit_rst_n),
		.clear(tx_clear),
		.base_tick(base_tick),
		.div_k(baud.div_k),
		.mid_tick(tx_mid),
		.bit_tick(tx_tick)
	);

	always_ff @(posedge SYS_CLK or negedge unit_rst_n)
	begin
		if (!unit_rst_n)
		begin
			tx_state <= TX_IDLE; // R04
			tx_data <= DATA_RST;
			tx_sh <= DATA_RST;
			tx_cnt <= 3'h0;
			tx_line <= 1'b1;
			TX_DONE_IRQ <= 1'b0;
		end
		else if (!mode.tx_en)
		begin
			tx_state <= TX_IDLE; // R06
			tx_sh <= DATA_RST;
			tx_cnt <= 3'h0;
			tx_line <= 1'b1;
			TX_DONE_IRQ <= 1'b0;
		end
		else
		begin
			TX_DONE_IRQ <= 1'b0;
			case (tx_state)
				TX_IDLE:
					if (tx_start)
					begin
						tx_data <= REG_WDATA;
						tx_sh <= REG_WDATA;
						tx_line <= 1'b0; // R19
						tx_state <= TX_START;
					end
					else
						tx_line <= 1'b1; // R25
				TX_START:
					if (tx_tick)
					begin
						tx_line <= tx_sh[0]; // R11
						tx_sh <= {1'b0, tx_sh[7:1]};
						tx_cnt <= 3'h0;
						tx_state <= TX_DATA;
					end
				TX_DATA:
					if (tx_tick)
					begin
						if (tx_cnt == last_bit)
						begin
							if (mode.parity == PAR_NONE)
							begin
								tx_line <= 1'b1; // R17
								tx_state <= TX_STOP1;
							end
							else
							begin
								tx_line <= tx_par_bit;
								tx_state <= TX_PARITY;
							end
						end
						else
						begin
							tx_line <= tx_sh[0];
							tx_sh <= {1'b0, tx_sh[7:1]};
							tx_cnt <= tx_cnt + 3'h1;
						end
					end
				TX_PARITY:
					if (tx_tick)
					begin
						tx_line <= 1'b1;
						tx_state <= TX_STOP1;
					end
				TX_STOP1:
					if (tx_tick)
					begin
						if (mode.stop2)
							tx_state <= TX_STOP2;
						else
						begin
							tx_state <= TX_IDLE; // R21
							TX_DONE_IRQ <= 1'b1; // R20
						end
					end
				TX_STOP2:
					if (tx_tick)
					begin
						tx_state <= TX_IDLE;
						TX_DONE_IRQ <= 1'b1; // R20
					end
				default:
					tx_state <= TX_IDLE;
			endcase
		end
	end

	// serial output pin, port latch takes over outside uart use
	assign tx_owns_pin = mode.power && mode.tx_en && !dir_reg[DIR_OUT_BIT]; // R10
	assign next_serial_out = tx_owns_pin ? tx_line : latch_reg[LATCH_OUT_BIT]; // R01

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SERIAL_OUT <= 1'b1;
			SERIAL_OUT_OE_N <= 1'b1;
		end
		else
		begin
			SERIAL_OUT <= next_serial_out;
			SERIAL_OUT_OE_N <= dir_reg[DIR_OUT_BIT];
		end
	end

	// receive input: synchronise, gate, two-sample match filter
	assign rx_raw = dir_reg[DIR_IN_BIT] ? rx_sync2 : 1'b1; // R10

	always_ff @(posedge SYS_CLK or negedge unit_rst_n)
	begin
		if (!unit_rst_n)
		begin
			rx_sync1 <= 1'b1; // R05
			rx_sync2 <= 1'b1;
			rx_filt <= 1'b1;
			rx_view <= 1'b1;
			rx_prev <= 1'b1;
		end
		else
		begin
			rx_sync1 <= SERIAL_IN;
			rx_sync2 <= rx_sync1;
			rx_prev <= rx_view;
			if (base_tick)
			begin
				rx_filt <= rx_raw;
				if (rx_filt == rx_raw)
					rx_view <= rx_raw;
			end
		end
	end

	assign rx_fall = rx_prev && !rx_view;
	assign rx_clear = !mode.rx_en || (rx_state == RX_IDLE);
	assign rx_char = mode.char8 ? rx_sh : {1'b0, rx_sh[7:1]};
	assign rx_finish = (rx_state == RX_STOP) && rx_mid;
	assign rx_perr = ((mode.parity == PAR_ODD) || (mode.parity == PAR_EVEN)) && // R16 R17
		((astu_char_parity(rx_char, mode.char8) ^ rx_pbit) != (mode.parity == PAR_ODD)); // R13 R15
	assign rx_ferr = !rx_view;
	assign rx_ovr = rx_full;
	assign rx_store = rx_finish && !rx_full;

	astu_bitclk u_rx_clk (
		.clk(SYS_CLK),
		.rst_n(unit_rst_n),
		.clear(rx_clear),
		.base_tick(base_tick),
		.div_k(baud.div_k),
		.mid_tick(rx_mid),
		.bit_tick(rx_tick)
	);

	always_ff @(posedge SYS_CLK or negedge unit_rst_n)
	begin
		if (!unit_rst_n)
		begin
			rx_state <= RX_IDLE;
			rx_sh <= DATA_RST;
			rx_cnt <= 3'h0;
			rx_pbit <= 1'b0;
			RX_DONE_IRQ <= 1'b0;
		end
		else if (!mode.rx_en)
		begin
			rx_state <= RX_IDLE; // R07
			rx_sh <= DATA_RST;
			rx_cnt <= 3'h0;
			rx_pbit <= 1'b0;
			RX_DONE_IRQ <= 1'b0;
		end
		else
		begin
			RX_DONE_IRQ <= rx_finish;
			case (rx_state)
				RX_IDLE:
					if (rx_fall)
						rx_state <= RX_START;
				RX_START:
					if (rx_mid)
					begin
						rx_cnt <= 3'h0;
						rx_state <= rx_view ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rx_mid)
					begin
						rx_sh <= {rx_view, rx_sh[7:1]};
						rx_cnt <= rx_cnt + 3'h1;
						if (rx_cnt == last_bit)
							rx_state <= (mode.parity == PAR_NONE) ? RX_STOP : RX_PARITY; // R17
					end
				RX_PARITY:
					if (rx_mid)
					begin
						rx_pbit <= rx_view;
						rx_state <= RX_STOP;
					end
				RX_STOP:
					if (rx_mid)
						rx_state <= RX_IDLE;
				default:
					rx_state <= RX_IDLE;
			endcase
		end
	end

	// error flags: a status read clears, a new error in the same cycle wins
	assign status_set = {5'h00, rx_finish && rx_perr, rx_finish && rx_ferr, rx_finish && rx_ovr};
	assign status_keep = rd_status ? 8'h00 : status_reg;

	always_ff @(posedge SYS_CLK or negedge unit_rst_n)
	begin
		if (!unit_rst_n)
		begin
			status_reg <= STATUS_RST; // R04
			rx_buf <= DATA_RST;
			rx_full <= 1'b0;
		end
		else
		begin
			status_reg <= mode.rx_en ? (status_keep | status_set) : STATUS_RST; // R07
			if (rx_store)
				rx_buf <= rx_char;
			rx_full <= mode.rx_en && (rx_store || (rx_full && !rd_rxbuf));
		end
	end

	a_stop_mode_pin: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R01
		(!mode.power && !dir_reg[DIR_OUT_BIT]) |=> (SERIAL_OUT == $past(latch_reg[LATCH_OUT_BIT])))
		else $error("stopped unit still drives the serial pin");

	a_mode_reset: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R02
		$rose(RST_N) |-> (mode_reg == MODE_RST))
		else $error("mode register not at its reset value");

	a_power_reset: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R04
		!mode.power |-> (tx_data == DATA_RST && rx_buf == DATA_RST && status_reg == STATUS_RST))
		else $error("power clear left unit data behind");

	a_input_forced: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R05
		!mode.power |-> (rx_view && rx_state == RX_IDLE && pre_cnt == 5'h00))
		else $error("receive input not held high while powered down");

	a_tx_disable: assert property (@(posedge SYS_CLK) disable iff (!unit_rst_n) // R06
		!mode.tx_en |=> (tx_state == TX_IDLE && tx_line && !TX_DONE_IRQ))
		else $error("transmitter active after enable clear");

	a_rx_disable: assert property (@(posedge SYS_CLK) disable iff (!unit_rst_n) // R07
		!mode.rx_en |=> (rx_state == RX_IDLE && status_reg == STATUS_RST))
		else $error("receiver active after enable clear");

	a_tx_start_bit: assert property (@(posedge SYS_CLK) disable iff (!unit_rst_n) // R18
		tx_start |=> (tx_state == TX_START && !tx_line && tx_data == $past(REG_WDATA)))
		else $error("write did not start a frame");

	a_parity_value: assert property (@(posedge SYS_CLK) disable iff (!unit_rst_n) // R12
		(tx_state == TX_PARITY) |-> (tx_line == ((mode.parity == PAR_EVEN) ?
			astu_char_parity(tx_data, mode.char8) : (mode.parity == PAR_ODD) ?
			!astu_char_parity(tx_data, mode.char8) : 1'b0)))
		else $error("wrong parity bit on the line");

	a_done_timing: assert property (@(posedge SYS_CLK) disable iff (!unit_rst_n) // R20
		(mode.tx_en && tx_tick && (tx_state == TX_STOP2 || (tx_state == TX_STOP1 && !mode.stop2)))
		|=> (TX_DONE_IRQ && tx_state == TX_IDLE) ##1 !TX_DONE_IRQ)
		else $error("transmit done not raised after last stop bit");

	a_idle_stays: assert property (@(posedge SYS_CLK) disable iff (!unit_rst_n) // R21
		(tx_state == TX_IDLE && !tx_start) |=> (tx_state == TX_IDLE && tx_line))
		else $error("transmitter left idle without new data");

	a_no_parity_err: assert property (@(posedge SYS_CLK) disable iff (!unit_rst_n) // R16
		(rx_finish && !mode.parity[1] && !status_reg[ST_PE_BIT] && !rd_status)
		|=> !status_reg[ST_PE_BIT])
		else $error("parity error flagged without parity check");

	a_pin_owner: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R10
		tx_owns_pin |=> (SERIAL_OUT == $past(tx_line) && !SERIAL_OUT_OE_N))
		else $error("serial pin not carrying transmit data");

endmodule // astu_top
`default_nettype wire

// ---- tb/astu_remote_uart.sv ----
// Purpose: remote serial receiver beside the transmit pin
// Assumes: fixed bit period in system clocks
// Notes: captures twelve bit slots after each falling edge seen while idle with oe_n low
`timescale 1ns/10ps
`default_nettype none
module astu_remote_uart
#(
	parameter int BIT_CYC = 32
)
(
	input wire logic clk,
	input wire logic line,
	input wire logic oe_n,
	output logic rx_line,
	output logic [11:0] frame,
	output int frame_cnt
);
	initial
	begin
		rx_line = 1'b1;
		frame = '1;
		frame_cnt = 0;
	end
	// samples each slot in its middle
	always
	begin
		@(negedge line);
		if (oe_n === 1'b0)
		begin
			repeat (BIT_CYC / 2) @(posedge clk);
			for (int i = 0; i < 12; i++)
			begin
				frame[i] = line;
				repeat (BIT_CYC) @(posedge clk);
			end
			frame_cnt++;
		end
	end
endmodule // astu_remote_uart
`default_nettype wire

// ---- tb/test_async_serial_transmit_unit.sv ----
// Purpose: self-checking bench of the transmit unit
// Assumes: bit period of 32 system clocks
// Notes: random data and formats, abort and power-down corners
`timescale 1ns/10ps
`default_nettype none
module test_async_serial_transmit_unit;
	import astu_pkg::*;
	logic clk, rst_n, wr, rd, tick, tx, oe_n, irq, rx_irq, ser_in;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, d;
	logic [11:0] frame;
	logic [1:0] par;
	logic c8, s2;
	int frame_cnt, failures, comparisons, m, nb, seed;
	astu_top dut (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TIMER_TICK_IN(tick),
		.SERIAL_IN(ser_in), .SERIAL_OUT(tx), .SERIAL_OUT_OE_N(oe_n),
		.TX_DONE_IRQ(irq), .RX_DONE_IRQ(rx_irq));
	astu_remote_uart #(.BIT_CYC(32)) far (.clk(clk), .line(tx), .oe_n(oe_n),
		.rx_line(ser_in), .frame(frame), .frame_cnt(frame_cnt));
	always #10 clk = ~clk;
	always @(posedge clk) tick <= ~tick;
	task automatic complete_run();
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_frame(input logic [11:0] g, input logic [11:0] e);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bound(input int n);
		if (n >= 1000)
		begin
			failures++;
			complete_run();
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_reg(rdata, e);
	endtask
	function automatic logic [11:0] exp_frame(input logic [7:0] v, input logic [1:0] p,
		input logic l8);
		logic [11:0] f;
		int n;
		logic odd;
		f = '1;
		n = l8 ? 8 : 7;
		odd = ^{v[7] & l8, v[6:0]};
		f[0] = 1'b0;
		for (int i = 0; i < n; i++)
			f[1 + i] = v[i];
		if (p == 2'b11)
			f[n + 1] = odd;
		else if (p == 2'b10)
			f[n + 1] = ~odd;
		else if (p == 2'b01)
			f[n + 1] = 1'b0;
		return f;
	endfunction
	// idle after a frame: no second request, line high
	task automatic quiet(input int cyc);
		int bad;
		bad = 0;
		repeat (cyc)
		begin
			@(posedge clk);
			#1;
			if (irq !== 1'b0 || tx !== 1'b1 || rx_irq !== 1'b0)
				bad++;
		end
		chk_bit(bad == 0, 1'b1);
	endtask
	task automatic send(input logic [7:0] v, input logic [11:0] ef, input int bits);
		int c0, n;
		c0 = frame_cnt;
		wr_reg(ADDR_TX_SHIFT, v);
		for (n = 1; n < 1000 && irq !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		bound(n);
		chk_bit(n >= bits * 32 - 2 && n <= bits * 32 + 6, 1'b1);
		quiet(1);
		for (n = 0; n < 1000 && frame_cnt == c0; n++)
			quiet(1);
		bound(n);
		chk_frame(frame, ef);
	endtask
	initial
	begin
		seed = $urandom(8755);
		clk = 1'b0;
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		tick = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		failures = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(ADDR_MODE, MODE_RST);
		rd_chk(ADDR_BAUD, BAUD_RST);
		rd_chk(ADDR_PORT_DIR, DIR_RST);
		rd_chk(16'hFF00, 8'h00);
		chk_bit(oe_n, 1'b1);
		wr_reg(ADDR_PORT_LATCH, 8'h08);
		wr_reg(ADDR_PORT_DIR, 8'hF5);
		for (m = 0; m < 10; m++)
		begin
			par = m[1:0];
			c8 = m[2] | (m == 8);
			s2 = $urandom() % 2;
			d = (m == 8) ? 8'hFF : (m == 9) ? 8'h00 : 8'($urandom());
			nb = 2 + (c8 ? 8 : 7) + (par != 2'b00) + s2;
			wr_reg(ADDR_BAUD, (m == 9) ? 8'h08 : 8'h48);
			wr_reg(ADDR_MODE, {3'b000, par, c8, s2, 1'b1});
			wr_reg(ADDR_MODE, {3'b100, par, c8, s2, 1'b1});
			wr_reg(ADDR_MODE, {3'b110, par, c8, s2, 1'b1});
			rd_chk(ADDR_MODE, {3'b110, par, c8, s2, 1'b1});
			repeat (4) @(posedge clk);
			send(d, exp_frame(d, par, c8), nb);
			wr_reg(ADDR_MODE, {3'b100, par, c8, s2, 1'b1});
		end
		wr_reg(ADDR_MODE, 8'hC5);
		wr_reg(ADDR_TX_SHIFT, 8'h00);
		repeat (100) @(posedge clk);
		wr_reg(ADDR_MODE, 8'h85);
		repeat (4) @(posedge clk);
		wr_reg(ADDR_TX_SHIFT, 8'h5A);
		quiet(500);
		wr_reg(ADDR_MODE, 8'hC5);
		repeat (4) @(posedge clk);
		send(8'hA5, exp_frame(8'hA5, 2'b00, 1'b1), 10);
		rd_chk(ADDR_TX_SHIFT, 8'hA5);
		wr_reg(ADDR_MODE, 8'h85);
		wr_reg(ADDR_MODE, 8'h05);
		rd_chk(ADDR_TX_SHIFT, DATA_RST);
		rd_chk(ADDR_RX_STATUS, STATUS_RST);
		rd_chk(ADDR_RX_BUFFER, DATA_RST);
		wr_reg(ADDR_TX_SHIFT, 8'h3C);
		quiet(100);
		wr_reg(ADDR_PORT_LATCH, 8'h00);
		repeat (2) @(posedge clk);
		chk_bit(tx, 1'b0);
		chk_bit(irq, 1'b0);
		complete_run();
	end
endmodule // test_async_serial_transmit_unit
`default_nettype wire
